// >>> inc/dgp_pkg.sv
// Package: register map, field positions and types of the dual GPIO port block
package dgp_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_PA_DATA = 4'h0;
  localparam logic [3:0] ADR_PB_DATA = 4'h1;
  localparam logic [3:0] ADR_PA_DIR = 4'h4;
  localparam logic [3:0] ADR_PB_DIR = 4'h5;
  localparam logic [3:0] ADR_PA_PUE = 4'hB;
  localparam logic [3:0] ADR_PB_PUE = 4'hC;
  localparam logic [3:0] ADR_STATUS = 4'hD;
  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int PA_W = 6;
  localparam int PB_W = 8;
  localparam int BIT_PA_IN_ONLY = 2;
  localparam int BIT_PA_CLKPIN = 4;
  localparam int BIT_AWU = 6;
  localparam int BIT_CLKOUT_EN = 7;
  localparam int BIT_ST_INTPIN = 0;
  localparam int BIT_ST_CLKOUT = 1;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] RST_PA_DIR = 6'h00;
  localparam logic [7:0] RST_PB_DIR = 8'h00;
  localparam logic [5:0] RST_PA_PUE = 6'h00;
  localparam logic [7:0] RST_PB_PUE = 8'h00;
  localparam logic RST_CLKOUT_EN = 1'b0;
  // ----------------------------------------------------------------
  // Oscillator modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OSC_INTERNAL = 2'b00,
    OSC_EXTCLK = 2'b01,
    OSC_RC = 2'b10,
    OSC_XTAL = 2'b11
  } dgp_osc_t;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dgp_bus_t;
  typedef struct packed {
    logic [5:0] pa_data;
    logic [5:0] pa_dir;
    logic [5:0] pa_pue;
    logic clkout_en;
    logic [7:0] pb_data;
    logic [7:0] pb_dir;
    logic [7:0] pb_pue;
    logic [7:0] rdata;
    logic [5:0] pa_out;
    logic [5:0] pa_oe;
    logic [5:0] pa_pu;
    logic [7:0] pb_out;
    logic [7:0] pb_oe;
    logic [7:0] pb_pu;
    logic int_pin;
  } dgp_state_t;
endpackage : dgp_pkg

// >>> core/dgp_top.sv
// Dual GPIO port block: port A (6 pins) and port B (8 pins) with register port
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module dgp_top (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire dgp_pkg::dgp_bus_t I_BUS,
  output logic [7:0] O_RDATA,
  input wire logic [5:0] I_PA_PIN,
  output logic [5:0] O_PA_OUT,
  output logic [5:0] O_PA_OE,
  output logic [5:0] O_PA_PU,
  input wire logic [7:0] I_PB_PIN,
  output logic [7:0] O_PB_OUT,
  output logic [7:0] O_PB_OE,
  output logic [7:0] O_PB_PU,
  input wire dgp_pkg::dgp_osc_t I_OSC_MODE,
  input wire logic I_OSC_CLK,
  input wire logic I_INT_PIN_FN_EN,
  input wire logic I_AWU_LATCH,
  input wire logic [5:0] I_KEYPAD_EN,
  output logic [5:0] O_KEYPAD_IN,
  output logic O_INT_PIN_LEVEL
);
  import dgp_pkg::*;

  dgp_state_t s_q;
  dgp_state_t s_d;
  logic clkout_act;
  logic [5:0] pa_oe_n;
  logic [5:0] pa_rd;
  logic [7:0] pb_rd;

  // ----------------------------------------------------------------
  // Pin control and read-back
  // ----------------------------------------------------------------
  always_comb begin
    clkout_act = s_q.clkout_en && (I_OSC_MODE == OSC_INTERNAL || I_OSC_MODE == OSC_RC);
    for (int i = 0; i < PA_W; i++) begin
      pa_rd[i] = s_q.pa_dir[i] ? s_q.pa_data[i] : I_PA_PIN[i];
    end
    pa_rd[BIT_PA_IN_ONLY] = I_INT_PIN_FN_EN ? 1'b0 : I_PA_PIN[BIT_PA_IN_ONLY];
    for (int i = 0; i < PB_W; i++) begin
      pb_rd[i] = s_q.pb_dir[i] ? s_q.pb_data[i] : I_PB_PIN[i];
    end
    pa_oe_n = s_q.pa_dir;
    pa_oe_n[BIT_PA_IN_ONLY] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (I_BUS.wr) begin
      case (I_BUS.addr)
        ADR_PA_DATA: begin
          s_d.pa_data = I_BUS.wdata[5:0];
        end
        ADR_PB_DATA: begin
          s_d.pb_data = I_BUS.wdata;
        end
        ADR_PA_DIR: begin
          s_d.pa_dir = I_BUS.wdata[5:0];
        end
        ADR_PB_DIR: begin
          s_d.pb_dir = I_BUS.wdata;
        end
        ADR_PA_PUE: begin
          s_d.pa_pue = I_BUS.wdata[5:0];
          s_d.clkout_en = I_BUS.wdata[BIT_CLKOUT_EN];
        end
        ADR_PB_PUE: begin
          s_d.pb_pue = I_BUS.wdata;
        end
        default: begin
          s_d.pa_pue = s_q.pa_pue;
        end
      endcase
    end
    s_d.int_pin = I_INT_PIN_FN_EN ? I_PA_PIN[BIT_PA_IN_ONLY] : 1'b1;
    s_d.rdata = 8'h00;
    if (I_BUS.rd) begin
      case (I_BUS.addr)
        ADR_PA_DATA: begin
          s_d.rdata = {1'b0, I_AWU_LATCH, pa_rd};
        end
        ADR_PB_DATA: begin
          s_d.rdata = pb_rd;
        end
        ADR_PA_DIR: begin
          s_d.rdata = {2'b00, s_q.pa_dir};
        end
        ADR_PB_DIR: begin
          s_d.rdata = s_q.pb_dir;
        end
        ADR_PA_PUE: begin
          s_d.rdata = {s_q.clkout_en, 1'b0, s_q.pa_pue};
        end
        ADR_PB_PUE: begin
          s_d.rdata = s_q.pb_pue;
        end
        ADR_STATUS: begin
          s_d.rdata = {6'h00, clkout_act, s_d.int_pin};
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
    s_d.pa_out = s_q.pa_data;
    s_d.pa_oe = pa_oe_n;
    s_d.pa_pu = s_q.pa_pue & ~s_q.pa_dir;
    if (clkout_act) begin
      s_d.pa_out[BIT_PA_CLKPIN] = I_OSC_CLK;
      s_d.pa_oe[BIT_PA_CLKPIN] = 1'b1;
      s_d.pa_pu[BIT_PA_CLKPIN] = 1'b0;
    end
    s_d.pb_out = s_q.pb_data;
    s_d.pb_oe = s_q.pb_dir;
    s_d.pb_pu = s_q.pb_pue & ~s_q.pb_dir;
  end

  // ----------------------------------------------------------------
  // State register; data latches keep their value through reset
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    s_q <= s_d;
    if (!I_RST_N) begin
      s_q.pa_dir <= RST_PA_DIR;
      s_q.pb_dir <= RST_PB_DIR;
      s_q.pa_pue <= RST_PA_PUE;
      s_q.pb_pue <= RST_PB_PUE;
      s_q.clkout_en <= RST_CLKOUT_EN;
      s_q.rdata <= 8'h00;
      s_q.pa_oe <= 6'h00;
      s_q.pb_oe <= 8'h00;
      s_q.pa_pu <= 6'h00;
      s_q.pb_pu <= 8'h00;
      s_q.pa_out <= 6'h00;
      s_q.pb_out <= 8'h00;
      s_q.int_pin <= 1'b1;
      s_q.pa_data <= s_q.pa_data;
      s_q.pb_data <= s_q.pb_data;
    end
  end

  // ----------------------------------------------------------------
  // Keypad interrupt pin taps
  // ----------------------------------------------------------------
  logic [5:0] kbi_q;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      kbi_q <= 6'h00;
    end else begin
      kbi_q <= I_PA_PIN & I_KEYPAD_EN;
    end
  end

  assign O_RDATA = s_q.rdata;
  assign O_PA_OUT = s_q.pa_out;
  assign O_PA_OE = s_q.pa_oe;
  assign O_PA_PU = s_q.pa_pu;
  assign O_PB_OUT = s_q.pb_out;
  assign O_PB_OE = s_q.pb_oe;
  assign O_PB_PU = s_q.pb_pu;
  assign O_KEYPAD_IN = kbi_q;
  assign O_INT_PIN_LEVEL = s_q.int_pin;
endmodule : dgp_top
`default_nettype wire

// >>> tb/dgp_top_properties.sv
// Checker: port-level properties of the dual GPIO port block
`timescale 1ns/10ps
`default_nettype none
module dgp_top_chk import dgp_pkg::*; (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire dgp_pkg::dgp_bus_t I_BUS,
  input wire logic [7:0] O_RDATA,
  input wire logic [5:0] I_PA_PIN,
  input wire logic [5:0] O_PA_OE,
  input wire logic [5:0] O_PA_PU,
  input wire logic [7:0] I_PB_PIN,
  input wire logic [7:0] O_PB_OE,
  input wire logic [7:0] O_PB_PU,
  input wire logic I_INT_PIN_FN_EN,
  input wire logic I_AWU_LATCH,
  input wire logic [5:0] I_KEYPAD_EN,
  input wire logic [5:0] O_KEYPAD_IN,
  input wire logic O_INT_PIN_LEVEL
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_rd(logic [3:0] a);
    I_BUS.rd && I_BUS.addr == a;
  endsequence
  property p_pu_a; (O_PA_PU & O_PA_OE) == 6'h00; endproperty
  property p_pu_b; (O_PB_PU & O_PB_OE) == 8'h00; endproperty
  property p_a2; !O_PA_OE[BIT_PA_IN_ONLY]; endproperty
  property p_rst;
    disable iff (1'b0) !I_RST_N |=> O_PA_OE == 6'h00 && O_PB_OE == 8'h00;
  endproperty
  property p_kp; $past(I_RST_N) |-> O_KEYPAD_IN == ($past(I_PA_PIN) & $past(I_KEYPAD_EN));
  endproperty
  property p_lvl; $past(I_RST_N) |-> O_INT_PIN_LEVEL ==
    ($past(I_INT_PIN_FN_EN) ? $past(I_PA_PIN[BIT_PA_IN_ONLY]) : 1'b1); endproperty
  property p_rd_b;
    s_rd(ADR_PB_DATA) |=> ((O_RDATA ^ $past(I_PB_PIN)) & ~O_PB_OE) == 8'h00;
  endproperty
  property p_rd_a; s_rd(ADR_PA_DATA) |=> O_RDATA[7:6] == {1'b0, $past(I_AWU_LATCH)}
    && ((O_RDATA[5:0] ^ $past(I_PA_PIN)) & ~O_PA_OE & 6'h3B) == 6'h00
    && O_RDATA[2] == ($past(I_PA_PIN[2]) & !$past(I_INT_PIN_FN_EN)); endproperty
  a_pu_a: assert property (p_pu_a) else $error("pullup on output A");
  a_pu_b: assert property (p_pu_b) else $error("pullup on output B");
  a_a2: assert property (p_a2) else $error("A2 driven");
  a_rst: assert property (p_rst) else $error("dir not cleared");
  a_kp: assert property (p_kp) else $error("keypad input");
  a_lvl: assert property (p_lvl) else $error("int pin level");
  a_rd_b: assert property (p_rd_b) else $error("B read");
  a_rd_a: assert property (p_rd_a) else $error("A read");
endmodule : dgp_top_chk
bind dgp_top dgp_top_chk u_chk (.I_REF_CLK, .I_RST_N, .I_BUS, .O_RDATA, .I_PA_PIN, .O_PA_OE,
  .O_PA_PU, .I_PB_PIN, .O_PB_OE, .O_PB_PU, .I_INT_PIN_FN_EN, .I_AWU_LATCH, .I_KEYPAD_EN,
  .O_KEYPAD_IN, .O_INT_PIN_LEVEL);
`default_nettype wire

// >>> tb/dgp_board.sv
// Board model: pin levels from drivers, external sources and pullups
`timescale 1ns/10ps
`default_nettype none
module dgp_board #(parameter int W = 8) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_pu,
  input wire logic [W-1:0] i_ext_en,
  input wire logic [W-1:0] i_ext,
  output logic [W-1:0] o_pin
);
  logic [W-1:0] flt_q = '0;
  // Undriven pins without pullup wander every cycle
  always_ff @(posedge i_clk) flt_q <= ~flt_q;
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & (i_pu | flt_q));
endmodule : dgp_board
`default_nettype wire

// >>> tb/testbench.sv
// Testbench: register and pin scenarios of the dual GPIO port block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dgp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, osc_clk = 1'b0, fn_en = 1'b0, awu = 1'b1, ext_on = 1'b1, lvl;
  dgp_bus_t bus = '0;
  dgp_osc_t osc = OSC_INTERNAL;
  logic [5:0] kp_en = 6'h0F, pa_ext = 6'h29, pa_pin, pa_out, pa_oe, pa_pu, kp_in;
  logic [7:0] pb_ext = 8'hA5, pb_pin, pb_out, pb_oe, pb_pu, rdata;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  dgp_top dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_BUS(bus), .O_RDATA(rdata),
    .I_PA_PIN(pa_pin), .O_PA_OUT(pa_out), .O_PA_OE(pa_oe), .O_PA_PU(pa_pu), .I_PB_PIN(pb_pin),
    .O_PB_OUT(pb_out), .O_PB_OE(pb_oe), .O_PB_PU(pb_pu), .I_OSC_MODE(osc), .I_OSC_CLK(osc_clk),
    .I_INT_PIN_FN_EN(fn_en), .I_AWU_LATCH(awu), .I_KEYPAD_EN(kp_en), .O_KEYPAD_IN(kp_in),
    .O_INT_PIN_LEVEL(lvl));
  dgp_board #(.W(6)) u_pa (.i_clk(clk), .i_oe(pa_oe), .i_out(pa_out), .i_pu(pa_pu),
    .i_ext_en({6{ext_on}}), .i_ext(pa_ext), .o_pin(pa_pin));
  dgp_board #(.W(8)) u_pb (.i_clk(clk), .i_oe(pb_oe), .i_out(pb_out), .i_pu(pb_pu),
    .i_ext_en({8{ext_on}}), .i_ext(pb_ext), .o_pin(pb_pin));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    #1 chk(rdata, e);
  endtask : rd
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADR_PA_DIR, 8'h00);
    rd(ADR_PB_DIR, 8'h00);
    rd(4'h2, 8'h00);
    chk(8'(kp_in), 8'h09);
    wr(ADR_PA_DATA, 8'hFF);
    rd(ADR_PA_DATA, 8'h69);
    wr(ADR_PA_DIR, 8'hFF);
    idle(1);
    chk(8'(pa_oe), 8'h3B);
    rd(ADR_PA_DATA, 8'h7B);
    pa_ext <= 6'h04;
    fn_en <= 1'b1;
    wr(ADR_PA_DIR, 8'h00);
    idle(1);
    rd(ADR_PA_DATA, 8'h40);
    pa_ext <= 6'h00;
    idle(2);
    chk(8'(lvl), 8'h00);
    fn_en <= 1'b0;
    idle(2);
    chk(8'(lvl), 8'h01);
    $display("test port_a done");
    ext_on <= 1'b0;
    wr(ADR_PA_PUE, 8'h3F);
    idle(1);
    chk(8'(pa_pu), 8'h3F);
    rd(ADR_PA_DATA, 8'h7F);
    wr(ADR_PA_DIR, 8'h01);
    idle(1);
    chk(8'(pa_pu), 8'h3E);
    ext_on <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      osc <= dgp_osc_t'(m);
      wr(ADR_PA_PUE, 8'h80);
      idle(2);
      chk(8'({pa_oe[4], pa_out[4]}), 8'({!m[0], m[0]}));
    end
    osc <= OSC_INTERNAL;
    osc_clk <= 1'b1;
    wr(ADR_PA_PUE, 8'h80);
    idle(2);
    chk(8'({pa_oe[4], pa_out[4]}), 8'h03);
    wr(ADR_PA_PUE, 8'h00);
    idle(1);
    chk(8'(pa_oe), 8'h01);
    $display("test pullup_clkout done");
    wr(ADR_PB_DATA, 8'h3C);
    wr(ADR_PB_DIR, 8'h0F);
    rd(ADR_PB_DATA, 8'hAC);
    wr(ADR_PB_PUE, 8'hFF);
    idle(1);
    chk(pb_oe, 8'h0F);
    chk(pb_pu, 8'hF0);
    chk(pb_out, 8'h3C);
    rst_n <= 1'b0;
    idle(2);
    chk(pb_oe, 8'h00);
    rst_n <= 1'b1;
    wr(ADR_PB_DIR, 8'hFF);
    rd(ADR_PB_DATA, 8'h3C);
    wr(ADR_PA_DIR, 8'h3F);
    rd(ADR_PA_DATA, 8'h7B);
    $display("test port_b_reset done");
    idle(1);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
